// ---- common/fsr_defs.svh ----
// Constants for the flash status register and its serial read path
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FSR_OP_READ_STATUS 8'h05
`define FSR_OP_WRITE_STATUS 8'h01
`define FSR_OP_WRITE_ENABLE 8'h06
`define FSR_OP_WRITE_DISABLE 8'h04

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define FSR_BIT_LOCK 7
`define FSR_BIT_FAIL 5
`define FSR_BIT_PIN 4

// ----------------------------------------
// Global protection codes in bits 5:2
// ----------------------------------------
`define FSR_GLOBAL_PROTECT 4'hF
`define FSR_GLOBAL_UNPROTECT 4'h0

// ----------------------------------------
// Summary codes, last bit index and reset values
// ----------------------------------------
`define FSR_PROT_NONE 2'h0
`define FSR_PROT_SOME 2'h1
`define FSR_PROT_ALL 2'h3
`define FSR_LAST_BIT 3'h7
`define FSR_RST_LOCK 1'h0
`define FSR_RST_WREN 1'h0
`define FSR_RST_FAIL 1'h0

`endif

// ---- common/fsr_pkg.sv ----
// Types for the flash status register block
`default_nettype none

package fsr_pkg;

	typedef enum logic [3:0] {
		ST_CMD = 4'h1,
		ST_READ = 4'h2,
		ST_WSR = 4'h4,
		ST_SKIP = 4'h8
	} fsr_st_e;

	typedef struct packed {
		fsr_st_e state;
		logic [2:0] cs_s;
		logic [2:0] sck_s;
		logic [2:0] si_s;
		logic [2:0] wp_s;
		logic cs_lvl;
		logic sck_lvl;
		logic si_lvl;
		logic wp_lvl;
		logic [7:0] shift;
		logic [2:0] cnt;
		logic wsr_pend;
		logic wsr_full;
		logic [7:0] wsr_data;
		logic lock;
		logic wr_en;
		logic fail;
		logic so;
		logic so_oe;
		logic gprot;
		logic gunprot;
	} fsr_state_s;

endpackage : fsr_pkg

`default_nettype wire

// ---- core/fsr_status.sv ----
// Status register and its serial read, write and enable commands
`include "fsr_defs.svh"
`default_nettype none

module fsr_status (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Serial pins
	input wire logic i_cs_n,
	input wire logic i_sck,
	input wire logic i_si,
	input wire logic i_wp_n,
	output logic o_so,
	output logic o_so_oe,
	// Device core state
	input wire logic i_busy,
	input wire logic i_seq_mode,
	input wire logic i_prot_some,
	input wire logic i_prot_all,
	// Operation completion
	input wire logic i_op_end,
	input wire logic i_op_fail,
	input wire logic i_op_abort,
	// Control to device core
	output logic o_lock,
	output logic o_write_enable,
	output logic o_global_protect,
	output logic o_global_unprotect
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic fsr_filter(
		input logic [2:0] sync,
		input logic lvl
	);
		logic res;
		res = lvl;
		if (sync[1] == sync[2]) begin
			res = sync[2];
		end
		return res;
	endfunction : fsr_filter

	function automatic logic [7:0] fsr_shift_in(
		input logic [7:0] cur,
		input logic bit_in
	);
		return {cur[6:0], bit_in};
	endfunction : fsr_shift_in

	// ----------------------------------------
	// State
	// ----------------------------------------
	fsr_pkg::fsr_state_s r_reg;
	fsr_pkg::fsr_state_s r_next;

	logic [7:0] status;
	logic [1:0] prot_sum;
	logic sck_rise;
	logic sck_fall;
	logic frame_end;
	logic [7:0] opcode;
	logic [7:0] wdata;
	logic lock_ok;

	// ----------------------------------------
	// Live status byte
	// ----------------------------------------
	// Summary code 10 can never appear
	// summary encoding
	always_comb begin
		prot_sum = `FSR_PROT_NONE;
		if (i_prot_all) begin
			prot_sum = `FSR_PROT_ALL;
		end else if (i_prot_some) begin
			prot_sum = `FSR_PROT_SOME;
		end
	end

	assign status = {r_reg.lock, i_seq_mode, r_reg.fail,
		r_reg.wp_lvl, prot_sum, r_reg.wr_en, i_busy};

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.gprot = 1'b0;
		r_next.gunprot = 1'b0;
		r_next.cs_s = {r_reg.cs_s[1:0], i_cs_n};
		r_next.sck_s = {r_reg.sck_s[1:0], i_sck};
		r_next.si_s = {r_reg.si_s[1:0], i_si};
		r_next.wp_s = {r_reg.wp_s[1:0], i_wp_n};
		r_next.cs_lvl = fsr_filter(r_reg.cs_s, r_reg.cs_lvl);
		r_next.sck_lvl = fsr_filter(r_reg.sck_s, r_reg.sck_lvl);
		r_next.si_lvl = fsr_filter(r_reg.si_s, r_reg.si_lvl);
		r_next.wp_lvl = fsr_filter(r_reg.wp_s, r_reg.wp_lvl);
		sck_rise = r_next.sck_lvl & ~r_reg.sck_lvl;
		sck_fall = ~r_next.sck_lvl & r_reg.sck_lvl;
		frame_end = r_next.cs_lvl & ~r_reg.cs_lvl;
		opcode = fsr_shift_in(r_reg.shift, r_reg.si_lvl);
		wdata = fsr_shift_in(r_reg.wsr_data, r_reg.si_lvl);
		lock_ok = 1'b0;

		// Operation end clears first, so a command set wins
		if (i_op_end) begin
			r_next.wr_en = 1'b0;
			r_next.fail = i_op_fail & ~i_op_abort;
		end

		if (r_next.cs_lvl) begin
			r_next.so_oe = 1'b0;
			r_next.state = fsr_pkg::ST_CMD;
			r_next.cnt = 3'h0;
			r_next.wsr_pend = 1'b0;
			r_next.wsr_full = 1'b0;
			if (frame_end && r_reg.wsr_pend) begin
				r_next.wr_en = 1'b0;
				lock_ok = r_reg.wsr_full && r_reg.wr_en &&
					!(!r_reg.wp_lvl && r_reg.lock &&
					!r_reg.wsr_data[`FSR_BIT_LOCK]);
				if (lock_ok) begin
					r_next.lock = r_reg.wsr_data[`FSR_BIT_LOCK];
					if (!r_reg.lock) begin
						r_next.gprot = (r_reg.wsr_data[5:2] ==
							`FSR_GLOBAL_PROTECT);
						r_next.gunprot = (r_reg.wsr_data[5:2] ==
							`FSR_GLOBAL_UNPROTECT);
					end
				end
			end
		end else begin
			case (r_reg.state)
				fsr_pkg::ST_CMD: begin
					r_next.so_oe = 1'b0;
					if (sck_rise) begin
						r_next.shift = opcode;
						r_next.cnt = r_reg.cnt + 3'h1;
						// act only on a full opcode
						if (r_reg.cnt == `FSR_LAST_BIT) begin
							r_next.state = fsr_pkg::ST_SKIP;
							if (opcode == `FSR_OP_READ_STATUS) begin
								r_next.state = fsr_pkg::ST_READ;
								r_next.cnt = `FSR_LAST_BIT;
							end
							if (opcode == `FSR_OP_WRITE_STATUS) begin
								r_next.state = fsr_pkg::ST_WSR;
								r_next.wsr_pend = 1'b1;
							end
							if (opcode == `FSR_OP_WRITE_ENABLE) begin
								r_next.wr_en = 1'b1;
							end
							if (opcode == `FSR_OP_WRITE_DISABLE) begin
								r_next.wr_en = 1'b0;
							end
						end
					end
				end
				fsr_pkg::ST_READ: begin
					if (sck_fall) begin
						r_next.so = status[r_reg.cnt];
						r_next.so_oe = 1'b1;
						r_next.cnt = r_reg.cnt - 3'h1;
					end
				end
				fsr_pkg::ST_WSR: begin
					r_next.so_oe = 1'b0;
					if (sck_rise) begin
						r_next.wsr_data = wdata;
						r_next.cnt = r_reg.cnt + 3'h1;
						// Extra bytes are ignored
						if (r_reg.cnt == `FSR_LAST_BIT) begin
							r_next.wsr_full = 1'b1;
							r_next.state = fsr_pkg::ST_SKIP;
						end
					end
				end
				fsr_pkg::ST_SKIP: begin
					r_next.so_oe = 1'b0;
				end
				default: begin
					r_next.state = fsr_pkg::ST_SKIP;
					r_next.so_oe = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_reg.state <= fsr_pkg::ST_CMD;
			r_reg.cs_s <= 3'h7;
			r_reg.sck_s <= 3'h0;
			r_reg.si_s <= 3'h0;
			r_reg.wp_s <= 3'h7;
			r_reg.cs_lvl <= 1'b1;
			r_reg.sck_lvl <= 1'b0;
			r_reg.si_lvl <= 1'b0;
			r_reg.wp_lvl <= 1'b1;
			r_reg.shift <= 8'h00;
			r_reg.cnt <= 3'h0;
			r_reg.wsr_pend <= 1'b0;
			r_reg.wsr_full <= 1'b0;
			r_reg.wsr_data <= 8'h00;
			r_reg.lock <= `FSR_RST_LOCK;
			r_reg.wr_en <= `FSR_RST_WREN;
			r_reg.fail <= `FSR_RST_FAIL;
			r_reg.so <= 1'b0;
			r_reg.so_oe <= 1'b0;
			r_reg.gprot <= 1'b0;
			r_reg.gunprot <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Core ignores sector protect commands while lock is high
	assign o_so = r_reg.so;
	assign o_so_oe = r_reg.so_oe;
	assign o_lock = r_reg.lock;
	assign o_write_enable = r_reg.wr_en;
	assign o_global_protect = r_reg.gprot;
	assign o_global_unprotect = r_reg.gunprot;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	logic read_fall;
	logic rd_op_done;
	logic [7:0] status_q;
	assign read_fall = !r_next.cs_lvl && sck_fall &&
		(r_reg.state == fsr_pkg::ST_READ);
	assign rd_op_done = !r_next.cs_lvl && sck_rise &&
		(r_reg.state == fsr_pkg::ST_CMD) &&
		(r_reg.cnt == `FSR_LAST_BIT) &&
		(opcode == `FSR_OP_READ_STATUS);
	assign status_q = status;

	release_out_a: assert property (
		r_reg.cs_lvl |-> !o_so_oe)
		else $error("serial output driven while deselected");

	read_start_a: assert property (
		rd_op_done |=> (r_reg.state == fsr_pkg::ST_READ) &&
			(r_reg.cnt == 3'h7))
		else $error("read opcode did not start status output");

	bit_value_a: assert property (
		read_fall |=> o_so_oe && (o_so == $past(status_q[r_reg.cnt])))
		else $error("output bit does not match live status");

	wrap_order_a: assert property (
		(read_fall && r_reg.cnt == 3'h0) |=> r_reg.cnt == 3'h7)
		else $error("bit order did not wrap to bit 7");

	lock_hold_a: assert property (
		(r_reg.lock && !r_reg.wp_lvl) |=> r_reg.lock)
		else $error("lock fell while write protect asserted");

	global_gate_a: assert property (
		(o_global_protect || o_global_unprotect) |->
			!$past(r_reg.lock, 2))
		else $error("global action while lock was set");

	wsr_clears_a: assert property (
		(frame_end && r_reg.wsr_pend) |=> !o_write_enable [*2])
		else $error("status write left enable set");

	abort_fail_a: assert property (
		(i_op_end && i_op_abort) |=> !r_reg.fail)
		else $error("aborted operation set fail flag");

	prot_code_a: assert property (
		status[3:2] != 2'h2)
		else $error("reserved protection summary reported");

	pin_live_a: assert property (
		$changed(i_wp_n) ##1 $stable(i_wp_n) [*4] |->
			status[`FSR_BIT_PIN] == i_wp_n)
		else $error("pin state bit does not follow pin");

	fail_refresh_a: assert property (
		i_op_end |=> r_reg.fail == $past(i_op_fail && !i_op_abort))
		else $error("fail flag not refreshed at operation end");

	op_enable_clear_a: assert property (
		(i_op_end && r_reg.cs_lvl) |=> !o_write_enable)
		else $error("operation end left enable set");

	cut_opcode_a: assert property (
		(frame_end && r_reg.state == fsr_pkg::ST_CMD && !i_op_end) |=>
			$stable(o_lock) && $stable(o_write_enable))
		else $error("partial opcode changed status");

	lock_store_a: assert property (
		(frame_end && r_reg.wsr_pend && lock_ok) |=>
			o_lock == $past(r_reg.wsr_data[`FSR_BIT_LOCK]))
		else $error("lock not taken from written bit 7");

	pulse_width_a: assert property (
		(o_global_protect || o_global_unprotect) |=>
			!o_global_protect && !o_global_unprotect)
		else $error("global action pulse longer than one cycle");

	bit_step_a: assert property (
		(read_fall && r_reg.cnt != 3'h0) |=> r_reg.cnt == $past(r_reg.cnt) - 3'h1)
		else $error("bit order not most significant first");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	enable_drop_c: cover property ($fell(o_write_enable));
	status_read_c: cover property (
		rd_op_done ##[1:300] (read_fall && r_reg.cnt == 3'h0));
	global_prot_c: cover property (o_global_protect);
	lock_set_c: cover property ($rose(o_lock));
	fail_set_c: cover property ($rose(r_reg.fail));

endmodule : fsr_status

`default_nettype wire

// ---- testbench/fsr_host_model.sv ----
// Host side model that drives mode 0 serial frames into the status block
`default_nettype none

module fsr_host_model (
	// Clock
	input wire logic i_sys_clk,
	// Serial pins
	input wire logic i_so,
	output var logic o_cs_n,
	output var logic o_sck,
	output var logic o_si
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clock stands low outside frames
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
	end

	task automatic half(input int h);
		repeat (h) @(negedge i_sys_clk);
	endtask : half

	task automatic frame(input logic [23:0] tx, input int n, input int h, output logic [15:0] rx);
		rx = 16'h0000;
		o_cs_n = 1'b0;
		half(4);
		for (int i = 0; i < n; i++) begin
			o_si = tx[23 - i];
			half(h);
			o_sck = 1'b1;
			half(h);
			if (i >= 8) rx = {rx[14:0], i_so};
			o_sck = 1'b0;
		end
		half(4);
		o_cs_n = 1'b1;
		half(12);
	endtask : frame
endmodule : fsr_host_model

`default_nettype wire

// ---- testbench/fsr_status_tb.sv ----
// Self-checking bench for the status register block
`include "fsr_defs.svh"
`default_nettype none

module fsr_status_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, sck, si, so, so_oe, lock, wr_en, gp, gu;
	logic wp_n = 1'b1, busy = 1'b0, seq = 1'b0, some = 1'b0, all = 1'b0;
	logic op_end = 1'b0, op_fail = 1'b0, op_abort = 1'b0;
	logic lock_m = 1'b0, wr_en_m = 1'b0, fail_m = 1'b0;
	logic [31:0] seed = 32'h0001_1F55;
	logic [15:0] rx;
	logic [9:0] wtab [7] = '{10'h280, 10'h33C, 10'h380, 10'h100, 10'h1BC, 10'h300, 10'h300};
	int bad_count = 0, comparisons = 0, cycles = 0, gp_n = 0, gu_n = 0;

	always #2 clk = ~clk;

	fsr_status u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
		.i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .i_busy(busy), .i_seq_mode(seq),
		.i_prot_some(some), .i_prot_all(all), .i_op_end(op_end), .i_op_fail(op_fail),
		.i_op_abort(op_abort), .o_lock(lock), .o_write_enable(wr_en), .o_global_protect(gp),
		.o_global_unprotect(gu));
	// Released line shows the inverse of the last bit
	fsr_host_model u_host (.i_sys_clk(clk), .i_so(so_oe ? so : !so), .o_cs_n(cs_n),
		.o_sck(sck), .o_si(si));

	always @(posedge clk) begin
		cycles <= cycles + 1;
		gp_n <= gp_n + int'(gp);
		gu_n <= gu_n + int'(gu);
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [7:0] exp_st();
		return {lock_m, seq, fail_m, wp_n, all, some | all, wr_en_m, busy};
	endfunction : exp_st

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic rd(input int h);
		logic [7:0] e1;
		e1 = exp_st();
		fork
			u_host.frame({`FSR_OP_READ_STATUS, 16'h0000}, 24, h, rx);
			begin
				repeat (4 + 38 * h) @(negedge clk);
				chk("output enable", 16'h0001, {15'h0, so_oe});
				busy = !busy;
			end
		join
		chk("status bytes", {e1, exp_st()}, rx);
		chk("release", 16'h0000, {15'h0, so_oe});
	endtask : rd

	task automatic wen();
		u_host.frame({`FSR_OP_WRITE_ENABLE, 16'h0000}, 8, 4, rx);
		wr_en_m = 1'b1;
		chk("enable set", 16'h0001, {15'h0, wr_en});
	endtask : wen

	task automatic op(input logic f, input logic a);
		op_fail = f;
		op_abort = a;
		op_end = 1'b1;
		@(negedge clk);
		op_end = 1'b0;
		fail_m = f & !a;
		wr_en_m = 1'b0;
		@(negedge clk);
		chk("enable after op", 16'h0000, {15'h0, wr_en});
		rd(4);
	endtask : op

	initial begin
		logic pl, gpe, gue;
		int g0, u0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk("reset outputs", 16'h0000, {12'h0, lock, wr_en, so_oe, gp});
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			{busy, seq, some, all, wp_n} = seed[4:0];
			rd(4);
		end
		$display("test random reads done");
		u_host.frame({`FSR_OP_WRITE_ENABLE, 16'h0000}, 7, 4, rx);
		chk("cut opcode", 16'h0000, {15'h0, wr_en});
		u_host.frame({`FSR_OP_READ_STATUS, 16'h0000}, 13, 4, rx);
		chk("release mid byte", 16'h0000, {15'h0, so_oe});
		wen();
		u_host.frame({`FSR_OP_WRITE_DISABLE, 16'h0000}, 8, 4, rx);
		wr_en_m = 1'b0;
		chk("enable cleared", 16'h0000, {15'h0, wr_en});
		$display("test cut frames done");
		wen();
		op(1'b1, 1'b0);
		op(1'b1, 1'b1);
		wen();
		op(1'b0, 1'b0);
		$display("test operation end done");
		for (int i = 0; i < 7; i++) begin
			wp_n = wtab[i][9];
			if (wtab[i][8]) wen();
			pl = lock_m;
			gpe = wtab[i][8] && !pl && wtab[i][5:2] == 4'hF;
			gue = wtab[i][8] && !pl && wtab[i][5:2] == 4'h0;
			if (wtab[i][8] && (wtab[i][7] || wp_n || !pl)) lock_m = wtab[i][7];
			wr_en_m = 1'b0;
			g0 = gp_n;
			u0 = gu_n;
			u_host.frame({`FSR_OP_WRITE_STATUS, wtab[i][7:0], 8'h00}, 16, 4, rx);
			chk("lock and globals", 16'({lock_m, 1'b0, gpe, 1'b0, gue}),
				16'({lock, 2'(gp_n - g0), 2'(gu_n - u0)}));
			rd(4);
		end
		$display("test status writes done");
		summarize();
	end
endmodule : fsr_status_tb

`default_nettype wire
